/* design/mscan_top.sv */
// memory scanner range, lock and trigger logic with apb register slave
//
// Contract
// - end address formed from high and low bytes
// - end address and trigger select reset zero
// - end address writes ignored while go set
// - four-bit selector picks fetch trigger source
// - trigger select upper nibble reads zero
// - go clears when address passes end, idle
// - current address increments after every fetch
// - on crc ready, fetch word and pass it
// - two-bit mode: triggered, peek, burst, concurrent
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mscan_top (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [7:0]                     paddr,
   input  wire logic [31:0]                    pwdata,
   output logic      [31:0]                    prdata,
   output logic                                pready,
   output logic                                pslverr,
   input  wire logic [mscan_pkg::NUM_TRIG-1:0] trig_in,
   input  wire logic                           crc_ready,
   input  wire logic                           irq_active,
   output mscan_pkg::mscan_mem_req_t           mem_req,
   input  wire mscan_pkg::mscan_crc_word_t     mem_resp,
   output mscan_pkg::mscan_crc_word_t          crc_word,
   output logic                                irq
);
   logic        scan_enable;                   // enable bit
   logic        scan_go_a;                     // go bit, hardware cleared
   logic        interrupt_management_select;   // interrupt override select
   mscan_pkg::mscan_mode_t mode;               // access mode
   logic [7:0]  end_address_high;              // end address bits 15..8
   logic [7:0]  end_address_low;               // end address bits 7..0
   logic [15:0] current_address;               // start and running pointer
   logic [3:0]  trigger_source_code;           // trigger selector
   logic [mscan_pkg::IRQ_BITS-1:0] irq_status; // sticky events
   logic [mscan_pkg::IRQ_BITS-1:0] irq_mask;   // enables
   logic        invalid;                       // pointer wrapped past top
   mscan_pkg::mscan_state_t state;             // fetch sequencer
   logic        trig_event;                    // selected trigger edge
   logic        trig_pending;                  // one latched trigger
   logic [15:0] fetched_word;                  // word from memory store
   logic        word_load;                     // store strobe
   logic        go_eff;                        // go after interrupt override
   logic        fetch_start;                   // sequencer leaves idle
   logic        fetch_done;                    // word handed to crc
   logic        scan_end;                      // range exhausted
   logic        apb_wr;                        // write access phase
   logic        apb_rd;                        // read access phase
   logic [mscan_pkg::IRQ_BITS-1:0] irq_events; // event pulses
   logic [15:0] end_address;                   // assembled end address
   logic [31:0] next_prdata;                   // read mux
   logic        next_pslverr;                  // unmapped address

   // address decode for the slave error on both reads and writes
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == mscan_pkg::ADDR_CONTROL)  || (a == mscan_pkg::ADDR_END_HIGH) ||
               (a == mscan_pkg::ADDR_END_LOW)  || (a == mscan_pkg::ADDR_CUR_HIGH) ||
               (a == mscan_pkg::ADDR_CUR_LOW)  || (a == mscan_pkg::ADDR_TRIG_SEL) ||
               (a == mscan_pkg::ADDR_IRQ_STAT) || (a == mscan_pkg::ADDR_IRQ_MASK);
   endfunction : mapped

   assign end_address = {end_address_high, end_address_low};
   // access phases decoded once
   assign apb_wr = psel & penable & pwrite;
   assign apb_rd = psel & penable & ~pwrite;
   // interrupt override forces go low without clearing it; peek ignores it
   assign go_eff = scan_go_a & scan_enable &
                   ~(interrupt_management_select & irq_active & (mode != mscan_pkg::MODE_PEEK));
   // scan is over when the pointer has passed the end and no cycle runs
   assign scan_end = (current_address > end_address) && (state == mscan_pkg::ST_IDLE);
   // triggered mode waits for a latched event; other modes run on ready
   assign fetch_start = (state == mscan_pkg::ST_IDLE) && go_eff && !scan_end && crc_ready &&
                        ((mode != mscan_pkg::MODE_TRIGGERED) || trig_pending);
   assign fetch_done = (state == mscan_pkg::ST_PASS);
   assign word_load = (state == mscan_pkg::ST_WAIT) && mem_resp.valid;
   assign irq_events[mscan_pkg::IRQ_DONE]  = scan_go_a & scan_end;
   assign irq_events[mscan_pkg::IRQ_FETCH] = fetch_done;

   mscan_trig_sel u_trig (
      .pclk                (pclk),
      .presetn             (presetn),
      .trig_in             (trig_in),
      .trigger_source_code (trigger_source_code),
      .trig_event          (trig_event)
   );

   mscan_fetch_reg u_word (
      .pclk      (pclk),
      .presetn   (presetn),
      .load      (word_load),
      .load_data (mem_resp.data),
      .word      (fetched_word)
   );

   // control register: enable, interrupt select, mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_enable                 <= 1'b0;
         interrupt_management_select <= 1'b0;
         mode                        <= mscan_pkg::MODE_CONCURRENT;
      end else if (apb_wr && paddr == mscan_pkg::ADDR_CONTROL) begin
         scan_enable                 <= pwdata[mscan_pkg::CTL_EN];
         interrupt_management_select <= pwdata[mscan_pkg::CTL_INTERRUPT_MANAGEMENT_SELECT];
         mode <= mscan_pkg::mscan_mode_t'(pwdata[mscan_pkg::CTL_MODE_HI:mscan_pkg::CTL_MODE_LO]);
      end
   end

   // go bit: software sets, hardware clears at end of range; the end wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_go_a <= 1'b0;
      end else if (scan_go_a && scan_end) begin
         scan_go_a <= 1'b0;
      end else if (apb_wr && paddr == mscan_pkg::ADDR_CONTROL) begin
         scan_go_a <= pwdata[mscan_pkg::CTL_GO];
      end
   end

   // end address bytes, locked while go is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         end_address_high <= mscan_pkg::RESET_BYTE;
         end_address_low  <= mscan_pkg::RESET_BYTE;
      end else if (apb_wr && !scan_go_a) begin
         if (paddr == mscan_pkg::ADDR_END_HIGH) begin
            end_address_high <= pwdata[7:0];
         end
         if (paddr == mscan_pkg::ADDR_END_LOW) begin
            end_address_low <= pwdata[7:0];
         end
      end
   end

   // current address: software load while go is clear, increment per fetch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         current_address <= mscan_pkg::RESET_ADDR;
         invalid         <= 1'b0;
      end else if (fetch_done) begin
         current_address <= current_address + mscan_pkg::ADDR_ONE;
         invalid         <= (current_address == 16'hFFFF);
      end else if (apb_wr && !scan_go_a) begin
         if (paddr == mscan_pkg::ADDR_CUR_HIGH) begin
            current_address[15:8] <= pwdata[7:0];
            invalid               <= 1'b0;
         end
         if (paddr == mscan_pkg::ADDR_CUR_LOW) begin
            current_address[7:0] <= pwdata[7:0];
            invalid              <= 1'b0;
         end
      end
   end

   // trigger selector; only the low nibble is stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trigger_source_code <= mscan_pkg::TRIGGER_SOURCE_CODE_MASK & 4'h0;
      end else if (apb_wr && paddr == mscan_pkg::ADDR_TRIG_SEL) begin
         trigger_source_code <= pwdata[3:0];
      end
   end

   // one trigger is remembered; extra events before the fetch are dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_pending <= 1'b0;
      end else if (mode != mscan_pkg::MODE_TRIGGERED || !go_eff) begin
         trig_pending <= 1'b0;
      end else if (trig_event) begin
         trig_pending <= 1'b1;
      end else if (fetch_start) begin
         trig_pending <= 1'b0;
      end
   end

   // fetch sequencer: request memory, wait for word, hand it on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= mscan_pkg::ST_IDLE;
      end else begin
         unique case (state)
            mscan_pkg::ST_IDLE: begin
               if (fetch_start) begin
                  state <= mscan_pkg::ST_READ;
               end
            end
            mscan_pkg::ST_READ: begin
               state <= mscan_pkg::ST_WAIT;
            end
            mscan_pkg::ST_WAIT: begin
               if (mem_resp.valid) begin
                  state <= mscan_pkg::ST_PASS;
               end
            end
            mscan_pkg::ST_PASS: begin
               state <= mscan_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // memory request valid for one cycle, in the read state only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_req <= '0;
      end else begin
         mem_req.valid <= fetch_start;
         mem_req.addr  <= current_address;
      end
   end

   // word to crc engine, one-cycle valid
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_word <= '0;
      end else begin
         crc_word.valid <= fetch_done;
         crc_word.data  <= fetched_word;
      end
   end

   // sticky status: set wins over write-one-to-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
      end else if (apb_wr && paddr == mscan_pkg::ADDR_IRQ_STAT) begin
         irq_status <= (irq_status & ~pwdata[mscan_pkg::IRQ_BITS-1:0]) | irq_events;
      end else begin
         irq_status <= irq_status | irq_events;
      end
   end

   // mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= '0;
      end else if (apb_wr && paddr == mscan_pkg::ADDR_IRQ_MASK) begin
         irq_mask <= pwdata[mscan_pkg::IRQ_BITS-1:0];
      end
   end

   // interrupt output registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // read mux; busy reflects a running cycle or a ready request
   always_comb begin
      next_prdata  = '0;
      next_pslverr = ~mapped(paddr);
      unique case (paddr)
         mscan_pkg::ADDR_CONTROL: begin
            next_prdata[mscan_pkg::CTL_EN]      = scan_enable;
            next_prdata[mscan_pkg::CTL_GO]      = scan_go_a;
            next_prdata[mscan_pkg::CTL_BUSY]    = (state != mscan_pkg::ST_IDLE) | (go_eff & crc_ready);
            next_prdata[mscan_pkg::CTL_INVALID] = invalid;
            next_prdata[mscan_pkg::CTL_INTERRUPT_MANAGEMENT_SELECT]    = interrupt_management_select;
            next_prdata[mscan_pkg::CTL_MODE_HI:mscan_pkg::CTL_MODE_LO] = mode;
         end
         mscan_pkg::ADDR_END_HIGH: next_prdata[7:0] = end_address_high;
         mscan_pkg::ADDR_END_LOW:  next_prdata[7:0] = end_address_low;
         mscan_pkg::ADDR_CUR_HIGH: next_prdata[7:0] = current_address[15:8];
         mscan_pkg::ADDR_CUR_LOW:  next_prdata[7:0] = current_address[7:0];
         mscan_pkg::ADDR_TRIG_SEL: next_prdata[3:0] = trigger_source_code;
         mscan_pkg::ADDR_IRQ_STAT: next_prdata[mscan_pkg::IRQ_BITS-1:0] = irq_status;
         mscan_pkg::ADDR_IRQ_MASK: next_prdata[mscan_pkg::IRQ_BITS-1:0] = irq_mask;
         default: next_prdata = '0;
      endcase
   end

   // apb answer registered during setup, valid in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else begin
         prdata  <= (psel && !penable && !pwrite) ? next_prdata : '0;
         pslverr <= psel && !penable && next_pslverr;
         pready  <= psel && !penable;
      end
   end
endmodule : mscan_top
`default_nettype wire

/* design/mscan_pkg.sv */
// package: register map, field layout, mode and trigger codes for the memory scan range/trigger block
package mscan_pkg;
   // register byte addresses (word aligned on apb)
   localparam logic [7:0] ADDR_CONTROL   = 8'h00;
   localparam logic [7:0] ADDR_END_HIGH  = 8'h04;
   localparam logic [7:0] ADDR_END_LOW   = 8'h08;
   localparam logic [7:0] ADDR_CUR_HIGH  = 8'h0C;
   localparam logic [7:0] ADDR_CUR_LOW   = 8'h10;
   localparam logic [7:0] ADDR_TRIG_SEL  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'h1C;
   // control register field positions
   localparam int CTL_EN      = 7;
   localparam int CTL_GO      = 6;
   localparam int CTL_BUSY    = 5;
   localparam int CTL_INVALID = 4;
   localparam int CTL_INTERRUPT_MANAGEMENT_SELECT    = 3;
   localparam int CTL_MODE_HI = 1;
   localparam int CTL_MODE_LO = 0;
   // interrupt status bit positions
   localparam int IRQ_DONE  = 0;
   localparam int IRQ_FETCH = 1;
   localparam int IRQ_BITS  = 2;
   // reset values, address step and trigger source limits
   localparam logic [7:0]  RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_ADDR = 16'h0000;
   localparam logic [15:0] ADDR_ONE   = 16'h0001;
   localparam logic [3:0]  TRIGGER_SOURCE_CODE_MASK  = 4'hF;
   localparam int          NUM_TRIG   = 10;
   localparam logic [3:0]  TRIGGER_SOURCE_CODE_LAST  = 4'h9;
   // access modes
   typedef enum logic [1:0] {
      MODE_CONCURRENT = 2'b00,
      MODE_BURST      = 2'b01,
      MODE_PEEK       = 2'b10,
      MODE_TRIGGERED  = 2'b11
   } mscan_mode_t;
   // fetch sequencer states
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WAIT  = 2'b10,
      ST_PASS  = 2'b11
   } mscan_state_t;
   // memory request and answer bundles
   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
   } mscan_mem_req_t;
   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } mscan_crc_word_t;
endpackage : mscan_pkg

/* design/mscan_trig_sel.sv */
// trigger source selector with rising edge detector
`timescale 1ns/1ps
`default_nettype none
module mscan_trig_sel (
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   input  wire logic [mscan_pkg::NUM_TRIG-1:0]    trig_in,
   input  wire logic [3:0]                        trigger_source_code,
   output logic                                   trig_event
);
   logic [mscan_pkg::NUM_TRIG-1:0] trig_prev;  // last sampled level per source
   logic [mscan_pkg::NUM_TRIG-1:0] trig_rise;  // rising edge per source

   // remember each source level one cycle back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_prev <= '0;
      end else begin
         trig_prev <= trig_in;
      end
   end

   // one edge detector per source
   genvar g;
   generate
      for (g = 0; g < mscan_pkg::NUM_TRIG; g++) begin : g_edge
         assign trig_rise[g] = trig_in[g] & ~trig_prev[g];
      end
   endgenerate

   // reserved codes select nothing, so no fetch can be paced by them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_event <= 1'b0;
      end else if (trigger_source_code <= mscan_pkg::TRIGGER_SOURCE_CODE_LAST) begin
         trig_event <= trig_rise[trigger_source_code];
      end else begin
         trig_event <= 1'b0;
      end
   end
endmodule : mscan_trig_sel
`default_nettype wire

/* design/mscan_fetch_reg.sv */
// small registered word store: holds the fetched word until the crc engine takes it
`timescale 1ns/1ps
`default_nettype none
module mscan_fetch_reg (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        load,
   input  wire logic [15:0] load_data,
   output logic      [15:0] word
);
   // data register updated only on load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word <= mscan_pkg::RESET_ADDR;
      end else if (load) begin
         word <= load_data;
      end
   end
endmodule : mscan_fetch_reg
`default_nettype wire

/* verification/mscan_top_asserts.sv */
// checker: port level assertions for the memory scan range and trigger block
`timescale 1ns/1ps
`default_nettype none
module mscan_top_asserts (
   input wire logic                           pclk,
   input wire logic                           presetn,
   input wire logic                           psel,
   input wire logic                           penable,
   input wire logic                           pwrite,
   input wire logic [7:0]                     paddr,
   input wire logic [31:0]                    pwdata,
   input wire logic [31:0]                    prdata,
   input wire logic                           pready,
   input wire logic [mscan_pkg::NUM_TRIG-1:0] trig_in,
   input wire logic                           crc_ready,
   input wire mscan_pkg::mscan_mem_req_t      mem_req,
   input wire mscan_pkg::mscan_crc_word_t     mem_resp,
   input wire mscan_pkg::mscan_crc_word_t     crc_word,
   input wire logic                           irq
);
   logic [1:0]  mode_q;  // mode last written
   logic [3:0]  code_q;  // trigger code last written
   logic [1:0]  mask_q;  // interrupt mask last written
   logic        pend_q;  // selected source rose since last fetch
   logic        sel_d;   // selected source one cycle ago
   logic [15:0] last_a;  // address of previous fetch
   logic        have_a;  // previous fetch is in the same run
   wire logic   wr_hit = psel && penable && pready && pwrite;
   // reserved codes select nothing; guard keeps the index in range
   wire logic   sel_now = (code_q <= mscan_pkg::TRIGGER_SOURCE_CODE_LAST) && trig_in[code_q];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // shadow of software configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {mode_q, code_q, mask_q} <= '0;
      end else if (wr_hit) begin
         if (paddr == mscan_pkg::ADDR_CONTROL) mode_q <= pwdata[1:0];
         if (paddr == mscan_pkg::ADDR_TRIG_SEL) code_q <= pwdata[3:0];
         if (paddr == mscan_pkg::ADDR_IRQ_MASK) mask_q <= pwdata[1:0];
      end
   end
   // trigger and fetch address history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {pend_q, sel_d, last_a, have_a} <= '0;
      end else begin
         sel_d <= sel_now;
         if (mem_req.valid) pend_q <= 1'b0;
         else if (sel_now && !sel_d) pend_q <= 1'b1;
         // pointer reload starts a new run
         if (wr_hit && (paddr == mscan_pkg::ADDR_CUR_HIGH || paddr == mscan_pkg::ADDR_CUR_LOW)) have_a <= 1'b0;
         else if (mem_req.valid) begin
            have_a <= 1'b1;
            last_a <= mem_req.addr;
         end
      end
   end
   sequence apb_setup_s;
      psel && !penable;
   endsequence
   sequence word_out_s;
      ##2 (crc_word.valid && crc_word.data == $past(mem_resp.data, 2));
   endsequence
   apb_answer_a: assert property (apb_setup_s |=> pready)
      else $error("no answer in first access cycle");
   byte_read_a: assert property ((pready && !pwrite) |-> prdata[31:8] == 24'h000000)
      else $error("read data wider than a byte");
   trig_upper_a: assert property ((pready && !pwrite && paddr == mscan_pkg::ADDR_TRIG_SEL) |-> prdata[7:4] == 4'h0)
      else $error("trigger select upper nibble not zero");
   req_ready_a: assert property (mem_req.valid |-> $past(crc_ready))
      else $error("fetch without crc ready");
   req_pulse_a: assert property (mem_req.valid |=> !mem_req.valid)
      else $error("fetch request longer than one cycle");
   word_pass_a: assert property (mem_resp.valid |-> word_out_s)
      else $error("memory word not passed on");
   addr_step_a: assert property ((mem_req.valid && have_a) |-> mem_req.addr == last_a + 16'h0001)
      else $error("fetch address did not step by one");
   trig_fetch_a: assert property ((mem_req.valid && mode_q == mscan_pkg::MODE_TRIGGERED) |-> pend_q)
      else $error("triggered fetch without trigger event");
   irq_masked_a: assert property ((mask_q == 2'h0 && $past(mask_q) == 2'h0) |-> !irq)
      else $error("interrupt while fully masked");
endmodule : mscan_top_asserts
bind mscan_top mscan_top_asserts u_asserts (.*);
`default_nettype wire

/* verification/mscan_mem_model.sv */
// partner: program memory and crc engine seen from the scanner
`timescale 1ns/1ps
`default_nettype none
module mscan_mem_model (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       slow,
   input  wire mscan_pkg::mscan_mem_req_t  mem_req,
   input  wire mscan_pkg::mscan_crc_word_t crc_word,
   output mscan_pkg::mscan_crc_word_t      mem_resp,
   output logic                            crc_ready
);
   logic [3:0]  mem_cnt;  // cycles left until the word returns
   logic [15:0] mem_a;    // address being read
   logic [3:0]  crc_cnt;  // cycles the crc engine stays busy
   // memory answers only a seen request, after one or four cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {mem_cnt, mem_a, mem_resp} <= '0;
      end else begin
         mem_resp.valid <= 1'b0;
         // released bus inverts every cycle, so the last word shows only on alternate cycles
         mem_resp.data <= ~mem_resp.data;
         if (mem_req.valid) begin
            mem_a   <= mem_req.addr;
            mem_cnt <= slow ? 4'h4 : 4'h1;
         end else if (mem_cnt == 4'h1) begin
            mem_resp.valid <= 1'b1;
            mem_resp.data  <= mem_a ^ 16'h5A3C;
            mem_cnt        <= 4'h0;
         end else if (mem_cnt != 4'h0) mem_cnt <= mem_cnt - 4'h1;
      end
   end
   // crc engine busy after each word, longer when slow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {crc_cnt, crc_ready} <= '0;
      end else begin
         if (crc_word.valid) crc_cnt <= slow ? 4'h6 : 4'h1;
         else if (crc_cnt != 4'h0) crc_cnt <= crc_cnt - 4'h1;
         crc_ready <= (crc_cnt == 4'h0) && !crc_word.valid;
      end
   end
endmodule : mscan_mem_model
`default_nettype wire

/* verification/memory_scan_range_trigger_test.sv */
// testbench: registers, scans in every mode, triggers and interrupt
`timescale 1ns/1ps
`default_nettype none
module memory_scan_range_trigger_test;
   logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic                       crc_ready, irq_active, irq, slow, err;
   logic [7:0]                 paddr;
   logic [31:0]                pwdata, prdata, rd;
   logic [9:0]                 trig_in;
   logic [15:0]                base, fin;
   logic [15:0]                got[$];
   mscan_pkg::mscan_mem_req_t  mem_req;
   mscan_pkg::mscan_crc_word_t mem_resp, crc_word;
   int                         errors, n_compared, m, code;
   int                         seed = 32'hce1f;
   mscan_top dut (.*);
   mscan_mem_model u_mem (.*);
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // words handed to the crc engine
   always @(posedge pclk) begin
      if (crc_word.valid === 1'b1) got.push_back(crc_word.data);
   end
   // interrupt noise; override is off so it must not matter
   always @(posedge pclk) irq_active <= 1'($random(seed));
   function automatic logic [31:0] exp_word(input logic [15:0] a);
      return {16'h0000, a ^ 16'h5A3C};
   endfunction : exp_word
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      // look mid-cycle: the answer stands until the edge that ends the access
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) errors++;
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask : rdchk
   task automatic pulse(input logic [9:0] v);
      trig_in <= v;
      repeat (2) @(posedge pclk);
      trig_in <= 10'h000;
      repeat (30) @(posedge pclk);
   endtask : pulse
   // load a random range of n words and start; end writes during the run are refused
   task automatic arm(input logic [1:0] mode, input int n);
      base = 16'h0100 + 16'($random(seed) & 32'h0FFF);
      fin = base + 16'(n) - 16'h0001;
      apb(1'b1, mscan_pkg::ADDR_CUR_HIGH, 32'(base[15:8]));
      apb(1'b1, mscan_pkg::ADDR_CUR_LOW, 32'(base[7:0]));
      apb(1'b1, mscan_pkg::ADDR_END_HIGH, 32'(fin[15:8]));
      apb(1'b1, mscan_pkg::ADDR_END_LOW, 32'(fin[7:0]));
      got.delete();
      apb(1'b1, mscan_pkg::ADDR_CONTROL, {24'h0, 6'h30, mode});
      apb(1'b1, mscan_pkg::ADDR_END_HIGH, {24'h0, ~fin[15:8]});
      apb(1'b1, mscan_pkg::ADDR_END_LOW, {24'h0, ~fin[7:0]});
   endtask : arm
   // wait for the run to end, then check words, range and interrupt
   task automatic finish;
      int k = 0;
      int n = int'(fin - base) + 1;
      do begin
         apb(1'b0, mscan_pkg::ADDR_CONTROL, 32'h0);
         k++;
      end while (rd[6] !== 1'b0 && k < 300);
      chk("go bit", 32'h0, 32'(rd[6]));
      repeat (8) @(posedge pclk);
      chk("word count", n, got.size());
      for (k = 0; k < n; k++) chk("word", exp_word(base + 16'(k)), 32'(got[k]));
      rdchk(mscan_pkg::ADDR_END_HIGH, 32'(fin[15:8]), "end high");
      rdchk(mscan_pkg::ADDR_END_LOW, 32'(fin[7:0]), "end low");
      fin = fin + 16'h0001;
      rdchk(mscan_pkg::ADDR_CUR_LOW, 32'(fin[7:0]), "current low");
      rdchk(mscan_pkg::ADDR_IRQ_STAT, 32'h3, "status");
      chk("irq masked", 32'h0, 32'(irq));
      apb(1'b1, mscan_pkg::ADDR_IRQ_MASK, 32'h1);
      repeat (3) @(posedge pclk);
      #1 chk("irq raised", 32'h1, 32'(irq));
      apb(1'b1, mscan_pkg::ADDR_IRQ_STAT, 32'h3);
      repeat (3) @(posedge pclk);
      #1 chk("irq cleared", 32'h0, 32'(irq));
      apb(1'b1, mscan_pkg::ADDR_IRQ_MASK, 32'h0);
   endtask : finish
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      test_done;
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, trig_in, slow, irq_active} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(mscan_pkg::ADDR_END_HIGH, 32'h0, "end high reset");
      rdchk(mscan_pkg::ADDR_END_LOW, 32'h0, "end low reset");
      rdchk(mscan_pkg::ADDR_TRIG_SEL, 32'h0, "trig reset");
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped error", 32'h1, 32'(err));
      // every code; random upper bits read back zero
      for (m = 0; m < 16; m++) begin
         apb(1'b1, mscan_pkg::ADDR_TRIG_SEL, {24'h0, 4'($random(seed)), 4'(m)});
         rdchk(mscan_pkg::ADDR_TRIG_SEL, 32'(m), "trig code");
      end
      // concurrent, burst and peek modes, prompt and stalling partner
      for (m = 0; m < 3; m++) begin
         slow <= m[0];
         arm(m[1:0], 3 + ($random(seed) & 3));
         finish;
      end
      // triggered mode: reserved code and wrong sources give nothing
      code = {$random(seed)} % 10;
      apb(1'b1, mscan_pkg::ADDR_TRIG_SEL, 32'hC);
      arm(2'b11, 2);
      pulse(10'h3FF);
      chk("reserved words", 32'h0, got.size());
      apb(1'b1, mscan_pkg::ADDR_TRIG_SEL, 32'(code));
      pulse(10'h3FF ^ (10'h001 << code));
      chk("other source words", 32'h0, got.size());
      pulse(10'h001 << code);
      chk("one per event", 32'h1, got.size());
      pulse(10'h001 << code);
      finish;
      test_done;
   end
endmodule : memory_scan_range_trigger_test
`default_nettype wire
